/* File: include/uv_bank_pkg.sv */
// Package for the UV result and status bank: address map, status bit layout,
// widths, reset values and cycle thresholds.
// Assumes a core clock of 100 MHz and byte-wide reads from the serial link side.
`default_nettype none
package uv_bank_pkg;

	// Word addresses of the output register bank.
	localparam logic [2:0] ADDR_STATUS  = 3'h0;
	localparam logic [2:0] ADDR_TEMP    = 3'h1;
	localparam logic [2:0] ADDR_CH_A    = 3'h2;
	localparam logic [2:0] ADDR_CH_B    = 3'h3;
	localparam logic [2:0] ADDR_CH_C    = 3'h4;
	localparam logic [2:0] ADDR_CONV_LO = 3'h5;
	localparam logic [2:0] ADDR_CONV_HI = 3'h6;

	// Status byte bit positions.
	localparam int STAT_PERIOD_OVF = 7;
	localparam int STAT_RESULT_OVF = 6;
	localparam int STAT_OVERDRIVE  = 5;
	localparam int STAT_LOST       = 4;
	localparam int STAT_NEW        = 3;
	localparam int STAT_BUSY       = 2;
	localparam int STAT_STANDBY    = 1;
	localparam int STAT_POWERDOWN  = 0;

	// Widths of the counters and results.
	localparam int CH_W     = 16;
	localparam int CONV_W   = 24;
	localparam int TEMP_W   = 12;
	localparam int NUM_CH   = 3;

	// Reset, cleared and saturation values.
	localparam logic [CH_W-1:0]   CH_ZERO   = 16'h0000;
	localparam logic [CH_W-1:0]   CH_MAX    = 16'hFFFF;
	localparam logic [CONV_W-1:0] CONV_ZERO = 24'h000000;
	localparam logic [7:0]        BYTE_ZERO = 8'h00;

	// Integration codes from which a result overflow can occur.
	localparam logic [3:0] OVF_CODE_MIN = 4'h7;

	// Least conversion period, in core clocks, for a full-resolution temperature.
	localparam logic [CONV_W-1:0] TEMP_MIN_PERIOD = 24'h001000;

	// Operating states of the bank; one-hot.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_MEAS = 2'b10
	} meas_state_t;

	// Link-side read states; one-hot.
	typedef enum logic [2:0] {
		LK_IDLE  = 3'b001,
		LK_WAIT  = 3'b010,
		LK_SERVE = 3'b100
	} link_state_t;

endpackage
`default_nettype wire

/* File: design/uv_link_reader.sv */
// Link-side reader: runs on the serial link clock, asks the core for a
// snapshot at each read start and serves bank words byte by byte.
// Assumes the core holds the words stable from its acknowledge until stop.
`timescale 1ns/100ps
`default_nettype none
module uv_link_reader
	import uv_bank_pkg::*;
(
	input  wire logic        link_clk,
	input  wire logic        rst_b,
	input  wire logic        rd_begin,
	input  wire logic [2:0]  rd_addr,
	input  wire logic        rd_end,
	input  wire logic        rd_byte_take,
	input  wire logic        ack_tgl,
	input  wire logic [15:0] word_status,
	input  wire logic [15:0] word_temp,
	input  wire logic [15:0] word_ch_a,
	input  wire logic [15:0] word_ch_b,
	input  wire logic [15:0] word_ch_c,
	input  wire logic [23:0] word_conv,
	output logic             req_tgl,
	output logic             stop_tgl,
	output logic [2:0]       req_addr,
	output logic [7:0]       rd_byte,
	output logic             rd_byte_valid
);

	link_state_t state_q, state_d;
	logic       req_tgl_q, req_tgl_d, stop_tgl_q, stop_tgl_d;
	logic [2:0] addr_q, addr_d, cur_q, cur_d;
	logic       hi_q, hi_d;
	logic [7:0] byte_q, byte_d;
	logic       valid_q, valid_d;
	logic       ack_s1_q, ack_s2_q, ack_s3_q, ack_st_q, ack_st_d;

	// Byte select for a word address; the low byte always leaves first.
	function automatic logic [7:0] pick_byte(input logic [2:0] a, input logic hi);
		logic [15:0] w;
		w = 16'h0000;
		unique case (a)
			ADDR_STATUS:  w = word_status;
			ADDR_TEMP:    w = word_temp;
			ADDR_CH_A:    w = word_ch_a;
			ADDR_CH_B:    w = word_ch_b;
			ADDR_CH_C:    w = word_ch_c;
			ADDR_CONV_LO: w = word_conv[15:0];
			ADDR_CONV_HI: w = {BYTE_ZERO, word_conv[23:16]};
			default:      w = 16'h0000;
		endcase
		return hi ? w[15:8] : w[7:0]; // R14
	endfunction

	// Read sequencing: request, wait for the core's acknowledge, then serve.
	always_comb
	begin
		state_d    = state_q;
		req_tgl_d  = req_tgl_q;
		stop_tgl_d = stop_tgl_q;
		addr_d     = addr_q;
		cur_d      = cur_q;
		hi_d       = hi_q;
		byte_d     = byte_q;
		valid_d    = valid_q;
		ack_st_d   = (ack_s2_q == ack_s3_q) ? ack_s3_q : ack_st_q;
		if (rd_end)
		begin
			stop_tgl_d = ~stop_tgl_q; // R9
			valid_d    = 1'b0;
			state_d    = LK_IDLE;
		end
		else if (rd_begin)
		begin
			// A repeated start re-requests so the new address clears its flags.
			req_tgl_d = ~req_tgl_q; // R8
			addr_d    = rd_addr;
			valid_d   = 1'b0;
			state_d   = LK_WAIT;
		end
		else
		begin
			unique case (state_q)
				LK_IDLE:
				begin
					valid_d = 1'b0;
				end
				LK_WAIT:
				begin
					if (ack_st_d != ack_st_q)
					begin
						cur_d   = addr_q;
						hi_d    = 1'b0;
						byte_d  = pick_byte(addr_q, 1'b0);
						valid_d = 1'b1;
						state_d = LK_SERVE;
					end
				end
				LK_SERVE:
				begin
					if (rd_byte_take)
					begin
						// After the high byte the address advances.
						if (hi_q)
						begin
							cur_d  = cur_q + 3'h1;
							byte_d = pick_byte(cur_q + 3'h1, 1'b0);
						end
						else
						begin
							byte_d = pick_byte(cur_q, 1'b1);
						end
						hi_d = ~hi_q;
					end
				end
			endcase
		end
	end

	// Registers of the link domain; the acknowledge passes three stages.
	always_ff @(posedge link_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q    <= LK_IDLE;
			req_tgl_q  <= 1'b0;
			stop_tgl_q <= 1'b0;
			addr_q     <= ADDR_STATUS;
			cur_q      <= ADDR_STATUS;
			hi_q       <= 1'b0;
			byte_q     <= BYTE_ZERO;
			valid_q    <= 1'b0;
			ack_s1_q   <= 1'b0;
			ack_s2_q   <= 1'b0;
			ack_s3_q   <= 1'b0;
			ack_st_q   <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			req_tgl_q  <= req_tgl_d;
			stop_tgl_q <= stop_tgl_d;
			addr_q     <= addr_d;
			cur_q      <= cur_d;
			hi_q       <= hi_d;
			byte_q     <= byte_d;
			valid_q    <= valid_d;
			ack_s1_q   <= ack_tgl;
			ack_s2_q   <= ack_s1_q;
			ack_s3_q   <= ack_s2_q;
			ack_st_q   <= ack_st_d;
		end
	end

	assign req_tgl       = req_tgl_q;
	assign stop_tgl      = stop_tgl_q;
	assign req_addr      = addr_q;
	assign rd_byte       = byte_q;
	assign rd_byte_valid = valid_q;

endmodule
`default_nettype wire

/* File: design/uv_result_status_bank.sv */
// Output side of the UV measurement engine: channel and period counters,
// buffer and result registers, status flags and the temperature result.
// Assumes engine strobes are synchronous to core_clk; reads arrive on link_clk.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: Set period overflow when 24-bit period counter wraps, gate mode with time reference.
// R2: Period counter restarts from zero after it overflows.
// R3: Set result overflow when any channel result overflows; integration codes 7..15 only.
// R4: An overflowing channel result saturates at all ones.
// R5: Set overdrive flag on input overdrive in a cycle; results then invalid.
// R6: Overflow and overdrive flags always describe the data in the result registers.
// R7: At cycle end, store counts in buffers and set the new data flag.
// R8: At each read start, copy all buffers into the result registers; the code skips it on a repeated start before stop.
// R9: While a read runs and no stop has come, results are not updated.
// R10: New data flag clears after reading status or a channel result.
// R11: Cycle ending while new data is pending overwrites buffers and sets lost data.
// R12: Lost data flag clears only on a status read.
// R13: Standby and power-down state bits show the live internal control signals.
// R14: A 16-bit result is read low byte first; the host assembles likewise.
// R15: Temperature at address one is 12 bits with the top four bits zero.
// R16: In gate mode without time reference, no temperature is measured.
// R17: Temperature is valid only for periods of at least 4096 core clocks; the code applies this only in gate mode with time reference.
// R18: Power-on reset, software reset or config return clears the whole bank; the latter two leave the channel and period counters as they are.
// R19: Busy status bit is the inverse of the ready pin.
// R20: Address zero in measurement state returns operational state then status.
// R21: Buffer capture runs even during a read; only the transfer waits.
module uv_result_status_bank
	import uv_bank_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         link_clk,
	input  wire logic         meas_start,
	input  wire logic         meas_end,
	input  wire logic [2:0]   ch_count_inc,
	input  wire logic         ch_overdrive,
	input  wire logic [11:0]  temp_sample,
	input  wire logic [3:0]   integration_code,
	input  wire logic         external_gate_mode,
	input  wire logic         time_ref_enable,
	input  wire logic         sleep_live,
	input  wire logic         shutdown_live,
	input  wire logic         in_measure_state,
	input  wire logic [7:0]   operational_state_reg,
	input  wire logic         soft_reset,
	input  wire logic         config_return,
	input  wire logic         rd_begin,
	input  wire logic [2:0]   rd_addr,
	input  wire logic         rd_end,
	input  wire logic         rd_byte_take,
	output logic [7:0]        rd_byte,
	output logic              rd_byte_valid,
	output logic              ready_out,
	output logic              temp_valid
);

	meas_state_t state_q, state_d;
	logic [CONV_W-1:0] period_q, period_d;
	logic [CH_W-1:0]   cnt_q [NUM_CH];
	logic [CH_W-1:0]   cnt_d [NUM_CH];
	logic [2:0]        run_flags_q, run_flags_d;
	logic [CH_W-1:0]   buf_ch_q [NUM_CH];
	logic [CH_W-1:0]   buf_ch_d [NUM_CH];
	logic [CH_W-1:0]   res_ch_q [NUM_CH];
	logic [CH_W-1:0]   res_ch_d [NUM_CH];
	logic [CONV_W-1:0] buf_conv_q, buf_conv_d, res_conv_q, res_conv_d;
	logic [TEMP_W-1:0] buf_temp_q, buf_temp_d, res_temp_q, res_temp_d;
	logic [2:0]        buf_flags_q, buf_flags_d, res_flags_q, res_flags_d;
	logic              buf_tok_q, buf_tok_d, temp_ok_q, temp_ok_d;
	logic              new_data_flag_q, new_data_flag_d, lost_data_flag_q, lost_data_flag_d;
	logic              lock_q, lock_d, ack_q, ack_d, ready_q, ready_d;
	logic [15:0]       snap_status_q, snap_status_d;
	logic              req_s1_q, req_s2_q, req_s3_q, req_st_q, req_st_d;
	logic              stp_s1_q, stp_s2_q, stp_s3_q, stp_st_q, stp_st_d;
	logic              req_tgl, stop_tgl;
	logic [2:0]        req_addr;

	// A channel word is read from address two to four.
	function automatic logic is_channel_addr(input logic [2:0] a);
		return (a == ADDR_CH_A) || (a == ADDR_CH_B) || (a == ADDR_CH_C);
	endfunction

	// Status byte as it stands now; flags come from the result side.
	function automatic logic [7:0] status_byte(input logic [2:0] f, input logic nd,
		input logic ld, input logic rdy);
		logic [7:0] s;
		s = BYTE_ZERO;
		s[STAT_PERIOD_OVF] = f[2]; // R6
		s[STAT_RESULT_OVF] = f[1];
		s[STAT_OVERDRIVE]  = f[0];
		s[STAT_LOST]       = ld;
		s[STAT_NEW]        = nd;
		s[STAT_BUSY]       = ~rdy; // R19
		s[STAT_STANDBY]    = sleep_live; // R13
		s[STAT_POWERDOWN]  = shutdown_live; // R13
		return s;
	endfunction

	// Engine side: counting during a measurement, capture at its end.
	always_comb
	begin
		logic clear_bank;
		logic capture;
		logic req_ev;
		logic stop_ev;
		logic [7:0] stat;
		clear_bank = soft_reset | config_return;
		capture    = 1'b0;
		stat       = BYTE_ZERO;
		state_d    = state_q;
		period_d   = period_q;
		run_flags_d = run_flags_q;
		buf_conv_d = buf_conv_q;
		buf_temp_d = buf_temp_q;
		buf_flags_d = buf_flags_q;
		buf_tok_d  = buf_tok_q;
		res_conv_d = res_conv_q;
		res_temp_d = res_temp_q;
		res_flags_d = res_flags_q;
		temp_ok_d  = temp_ok_q;
		new_data_flag_d    = new_data_flag_q;
		lost_data_flag_d    = lost_data_flag_q;
		lock_d     = lock_q;
		ack_d      = ack_q;
		snap_status_d = snap_status_q;
		for (int i = 0; i < NUM_CH; i++)
		begin
			cnt_d[i]    = cnt_q[i];
			buf_ch_d[i] = buf_ch_q[i];
			res_ch_d[i] = res_ch_q[i];
		end
		req_st_d = (req_s2_q == req_s3_q) ? req_s3_q : req_st_q;
		stp_st_d = (stp_s2_q == stp_s3_q) ? stp_s3_q : stp_st_q;
		req_ev   = req_st_d != req_st_q;
		stop_ev  = stp_st_d != stp_st_q;

		unique case (state_q)
			ST_IDLE:
			begin
				if (meas_start)
				begin
					state_d     = ST_MEAS;
					period_d    = CONV_ZERO;
					run_flags_d = 3'b000;
					for (int i = 0; i < NUM_CH; i++)
						cnt_d[i] = CH_ZERO;
				end
			end
			ST_MEAS:
			begin
				// The period reference only runs in gate mode with it enabled.
				if (external_gate_mode && time_ref_enable)
				begin
					period_d = period_q + 24'h000001; // R2
					if (period_q == {CONV_W{1'b1}})
						run_flags_d[2] = 1'b1; // R1
				end
				for (int i = 0; i < NUM_CH; i++)
				begin
					if (ch_count_inc[i])
					begin
						if (cnt_q[i] == CH_MAX)
						begin
							// Saturate rather than wrap so the reading stays a bound.
							if (integration_code >= OVF_CODE_MIN)
								run_flags_d[1] = 1'b1; // R3
						end
						else
						begin
							cnt_d[i] = cnt_q[i] + 16'h0001; // R4
						end
					end
				end
				if (ch_overdrive)
					run_flags_d[0] = 1'b1; // R5
				if (meas_end)
				begin
					state_d = ST_IDLE;
					capture = 1'b1;
				end
			end
		endcase

		// Capture into the buffers is never held off by a read.
		if (capture)
		begin
			for (int i = 0; i < NUM_CH; i++)
				buf_ch_d[i] = cnt_d[i]; // R7 R21
			buf_conv_d  = period_d;
			buf_flags_d = run_flags_d;
			buf_temp_d  = (external_gate_mode && !time_ref_enable) ? 12'h000 : temp_sample; // R16
			buf_tok_d   = !external_gate_mode || !time_ref_enable ||
				(period_d >= TEMP_MIN_PERIOD); // R17
		end

		// A read start transfers once, then the results stay put until stop.
		if (req_ev)
		begin
			if (!lock_q)
			begin
				for (int i = 0; i < NUM_CH; i++)
					res_ch_d[i] = buf_ch_q[i]; // R8
				res_conv_d  = buf_conv_q;
				res_temp_d  = buf_temp_q;
				res_flags_d = buf_flags_q; // R6
				temp_ok_d   = buf_tok_q & ~(external_gate_mode & ~time_ref_enable);
				lock_d      = 1'b1; // R9
			end
			stat = status_byte(lock_q ? res_flags_q : buf_flags_q, new_data_flag_q, lost_data_flag_q, ready_q);
			snap_status_d = in_measure_state ? {stat, operational_state_reg} :
				{BYTE_ZERO, stat}; // R20
			if ((req_addr == ADDR_STATUS) || is_channel_addr(req_addr))
				new_data_flag_d = 1'b0; // R10
			if (req_addr == ADDR_STATUS)
				lost_data_flag_d = 1'b0; // R12
			ack_d = ~ack_q;
		end
		if (stop_ev)
			lock_d = 1'b0; // R9

		// Capture wins over a read clearing the flags in the same cycle.
		if (capture)
		begin
			if (new_data_flag_q)
				lost_data_flag_d = 1'b1; // R11
			new_data_flag_d = 1'b1; // R7
		end

		if (clear_bank)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				buf_ch_d[i] = CH_ZERO; // R18
				res_ch_d[i] = CH_ZERO;
			end
			buf_conv_d  = CONV_ZERO;
			res_conv_d  = CONV_ZERO;
			buf_temp_d  = 12'h000;
			res_temp_d  = 12'h000;
			buf_flags_d = 3'b000;
			res_flags_d = 3'b000;
			buf_tok_d   = 1'b0;
			temp_ok_d   = 1'b0;
			new_data_flag_d     = 1'b0;
			lost_data_flag_d     = 1'b0;
			state_d     = ST_IDLE;
		end
		ready_d = (state_d == ST_IDLE); // R19
	end

	// Core-domain registers; read toggles pass three stages before use.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q       <= ST_IDLE;
			period_q      <= CONV_ZERO;
			run_flags_q   <= 3'b000;
			buf_conv_q    <= CONV_ZERO;
			res_conv_q    <= CONV_ZERO;
			buf_temp_q    <= 12'h000;
			res_temp_q    <= 12'h000;
			buf_flags_q   <= 3'b000;
			res_flags_q   <= 3'b000;
			buf_tok_q     <= 1'b0;
			temp_ok_q     <= 1'b0;
			new_data_flag_q       <= 1'b0;
			lost_data_flag_q       <= 1'b0;
			lock_q        <= 1'b0;
			ack_q         <= 1'b0;
			ready_q       <= 1'b1;
			snap_status_q <= 16'h0000;
			req_s1_q      <= 1'b0;
			req_s2_q      <= 1'b0;
			req_s3_q      <= 1'b0;
			req_st_q      <= 1'b0;
			stp_s1_q      <= 1'b0;
			stp_s2_q      <= 1'b0;
			stp_s3_q      <= 1'b0;
			stp_st_q      <= 1'b0;
			for (int i = 0; i < NUM_CH; i++)
			begin
				cnt_q[i]    <= CH_ZERO; // R18
				buf_ch_q[i] <= CH_ZERO;
				res_ch_q[i] <= CH_ZERO;
			end
		end
		else
		begin
			state_q       <= state_d;
			period_q      <= period_d;
			run_flags_q   <= run_flags_d;
			buf_conv_q    <= buf_conv_d;
			res_conv_q    <= res_conv_d;
			buf_temp_q    <= buf_temp_d;
			res_temp_q    <= res_temp_d;
			buf_flags_q   <= buf_flags_d;
			res_flags_q   <= res_flags_d;
			buf_tok_q     <= buf_tok_d;
			temp_ok_q     <= temp_ok_d;
			new_data_flag_q       <= new_data_flag_d;
			lost_data_flag_q       <= lost_data_flag_d;
			lock_q        <= lock_d;
			ack_q         <= ack_d;
			ready_q       <= ready_d;
			snap_status_q <= snap_status_d;
			req_s1_q      <= req_tgl;
			req_s2_q      <= req_s1_q;
			req_s3_q      <= req_s2_q;
			req_st_q      <= req_st_d;
			stp_s1_q      <= stop_tgl;
			stp_s2_q      <= stp_s1_q;
			stp_s3_q      <= stp_s2_q;
			stp_st_q      <= stp_st_d;
			for (int i = 0; i < NUM_CH; i++)
			begin
				cnt_q[i]    <= cnt_d[i];
				buf_ch_q[i] <= buf_ch_d[i];
				res_ch_q[i] <= res_ch_d[i];
			end
		end
	end

	// Link side; the words it reads are held still from acknowledge to stop.
	uv_link_reader u_link (
		.link_clk      (link_clk),
		.rst_b         (rst_b),
		.rd_begin      (rd_begin),
		.rd_addr       (rd_addr),
		.rd_end        (rd_end),
		.rd_byte_take  (rd_byte_take),
		.ack_tgl       (ack_q),
		.word_status   (snap_status_q),
		.word_temp     ({4'h0, res_temp_q}), // R15
		.word_ch_a     (res_ch_q[0]),
		.word_ch_b     (res_ch_q[1]),
		.word_ch_c     (res_ch_q[2]),
		.word_conv     (res_conv_q),
		.req_tgl       (req_tgl),
		.stop_tgl      (stop_tgl),
		.req_addr      (req_addr),
		.rd_byte       (rd_byte),
		.rd_byte_valid (rd_byte_valid)
	);

	assign ready_out  = ready_q;
	assign temp_valid = temp_ok_q;

endmodule
`default_nettype wire

/* File: tb/uv_link_host.sv */
// Host model on the link side: opens reads, takes bytes, sends stop.
// Assumes calls from the bench; it changes pins only at link_clk falls.
`timescale 1ns/100ps
`default_nettype none
module uv_link_host (
	input  wire logic  link_clk,
	input  wire logic  rd_byte_valid,
	output logic       rd_begin,
	output logic [2:0] rd_addr,
	output logic       rd_end,
	output logic       rd_byte_take
);
	int timeouts = 0;

	// Idle pins; the address is not meaningful until a read opens.
	initial
	begin
		{rd_begin, rd_end, rd_byte_take} = 3'h0;
		rd_addr = 3'h5;
	end

	// One read; gap stalls before each take, keep leaves the read open.
	task automatic xfer(input logic [2:0] a, input int n, input int gap, input bit keep);
		int k;
		@(negedge link_clk);
		rd_begin <= 1'b1;
		rd_addr  <= a;
		@(negedge link_clk);
		rd_begin <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			k = 0;
			while (rd_byte_valid !== 1'b1 && k < 20)
			begin
				@(negedge link_clk);
				k++;
			end
			if (k == 20)
				timeouts++;
			repeat (gap) @(negedge link_clk);
			rd_byte_take <= 1'b1;
			@(negedge link_clk);
			rd_byte_take <= 1'b0;
			@(negedge link_clk);
		end
		if (!keep)
			stop();
	endtask

	// Stop and, in the same cycle, park the address on its inverse so stale values never pass.
	task automatic stop;
		@(negedge link_clk);
		rd_end  <= 1'b1;
		rd_addr <= ~rd_addr;
		@(negedge link_clk);
		rd_end <= 1'b0;
		repeat (2) @(negedge link_clk);
	endtask
endmodule
`default_nettype wire

/* File: tb/uv_result_status_bank_monitor.sv */
// Checker for the UV result bank, seeing only its top ports.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/100ps
`default_nettype none
module uv_bank_monitor (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       link_clk,
	input wire logic       meas_start,
	input wire logic       meas_end,
	input wire logic       soft_reset,
	input wire logic       config_return,
	input wire logic       rd_begin,
	input wire logic       rd_end,
	input wire logic       rd_byte_take,
	input wire logic [7:0] rd_byte,
	input wire logic       rd_byte_valid,
	input wire logic       ready_out,
	input wire logic       temp_valid
);
	// Either clear returns the bank to idle.
	wire logic clr = soft_reset | config_return;

	property p_start_busy;
		@(posedge core_clk) disable iff (!rst_b)
		meas_start && ready_out && !clr |=> !ready_out;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy not raised");

	property p_start_refused;
		@(posedge core_clk) disable iff (!rst_b)
		meas_start && !ready_out && !meas_end && !clr |=> !ready_out;
	endproperty
	a_start_refused: assert property (p_start_refused) else $error("start in run");

	property p_end_ready;
		@(posedge core_clk) disable iff (!rst_b)
		meas_end && !ready_out |=> ready_out;
	endproperty
	a_end_ready: assert property (p_end_ready) else $error("ready not back");

	property p_clear;
		@(posedge core_clk) disable iff (!rst_b)
		clr |=> ready_out && !temp_valid;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	// A read left alone for seven link cycles after its start must be answered.
	sequence s_read_open;
		rd_begin && !rd_end ##1 (!rd_begin && !rd_end)[*7];
	endsequence

	property p_answer;
		@(posedge link_clk) disable iff (!rst_b)
		s_read_open |-> rd_byte_valid;
	endproperty
	a_answer: assert property (p_answer) else $error("no byte offered");

	property p_begin_drops;
		@(posedge link_clk) disable iff (!rst_b)
		rd_begin |=> !rd_byte_valid;
	endproperty
	a_begin_drops: assert property (p_begin_drops) else $error("stale byte");

	property p_stop_drops;
		@(posedge link_clk) disable iff (!rst_b)
		rd_end |=> !rd_byte_valid;
	endproperty
	a_stop_drops: assert property (p_stop_drops) else $error("valid after stop");

	property p_byte_hold;
		@(posedge link_clk) disable iff (!rst_b)
		rd_byte_valid && !rd_byte_take && !rd_begin && !rd_end
			|=> rd_byte_valid && $stable(rd_byte);
	endproperty
	a_byte_hold: assert property (p_byte_hold) else $error("byte moved");
endmodule

bind uv_result_status_bank uv_bank_monitor u_mon (
	.core_clk, .rst_b, .link_clk, .meas_start, .meas_end, .soft_reset,
	.config_return, .rd_begin, .rd_end, .rd_byte_take, .rd_byte,
	.rd_byte_valid, .ready_out, .temp_valid
);
`default_nettype wire

/* File: tb/uv_result_status_bank_tb.sv */
// Bench for the UV result bank: engine stimulus, host reads, scoreboard.
// Assumes the package, host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module uv_result_status_bank_tb
	import uv_bank_pkg::*;
;
	logic        core_clk, link_clk, rst_b, meas_start, meas_end, ch_overdrive;
	logic        external_gate_mode, time_ref_enable, sleep_live, shutdown_live;
	logic        in_measure_state, soft_reset, config_return, rd_begin, rd_end;
	logic        rd_byte_take, rd_byte_valid, ready_out, temp_valid;
	logic [2:0]  ch_count_inc, rd_addr;
	logic [11:0] temp_sample, t;
	logic [3:0]  integration_code;
	logic [7:0]  operational_state_reg, rd_byte, exp_b;
	logic [7:0]  exp_q[$];
	int          failures = 0, num_checks = 0, na, nb, nc;

	// Core clock 10 ns; link clock 160 ns with an unrelated phase.
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end

	uv_result_status_bank u_dut (
		.core_clk, .rst_b, .link_clk, .meas_start, .meas_end, .ch_count_inc,
		.ch_overdrive, .temp_sample, .integration_code, .external_gate_mode,
		.time_ref_enable, .sleep_live, .shutdown_live, .in_measure_state,
		.operational_state_reg, .soft_reset, .config_return, .rd_begin, .rd_addr,
		.rd_end, .rd_byte_take, .rd_byte, .rd_byte_valid, .ready_out, .temp_valid
	);

	uv_link_host u_host (.link_clk, .rd_byte_valid, .rd_begin, .rd_addr, .rd_end,
		.rd_byte_take);

	// Scoreboard: each byte the host takes meets the oldest note.
	always @(posedge link_clk)
		if (rd_byte_valid === 1'b1 && rd_byte_take === 1'b1)
		begin
			exp_b = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
			`CHK(rd_byte, exp_b)
		end

	// Status byte as the bank should show it; live bits come from the pins.
	function automatic logic [7:0] st(input bit rov, od, lost, nw, busy);
		logic [7:0] s;
		s = 8'h00;
		s[STAT_RESULT_OVF] = rov;
		s[STAT_OVERDRIVE]  = od;
		s[STAT_LOST]       = lost;
		s[STAT_NEW]        = nw;
		s[STAT_BUSY]       = busy;
		s[STAT_STANDBY]    = sleep_live;
		s[STAT_POWERDOWN]  = shutdown_live;
		return s;
	endfunction

	task automatic ps(input logic [7:0] s);
		exp_q.push_back(in_measure_state ? operational_state_reg : s);
		exp_q.push_back(in_measure_state ? s : BYTE_ZERO);
	endtask

	task automatic pw(input logic [15:0] w);
		exp_q.push_back(w[7:0]);
		exp_q.push_back(w[15:8]);
	endtask

	task automatic rd(input logic [2:0] a, input int n, input bit keep = 1'b0);
		u_host.xfer(a, n, $urandom % 3, keep);
		if (u_host.timeouts != 0)
		begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic start_m;
		@(negedge core_clk);
		meas_start = 1'b1;
		@(negedge core_clk);
		meas_start = 1'b0;
	endtask

	// The sample line flips after the end strobe to prove it was captured then.
	task automatic end_m(input logic [11:0] tt);
		ch_count_inc = 3'h0;
		ch_overdrive = 1'b0;
		@(negedge core_clk);
		temp_sample = tt;
		meas_end = 1'b1;
		@(negedge core_clk);
		meas_end = 1'b0;
		temp_sample = ~tt;
		cyc(2);
	endtask

	task automatic measure(input int a, b, c, len, input bit od, input logic [11:0] tt);
		start_m();
		for (int k = 0; k < len; k++)
		begin
			ch_count_inc = {k < c, k < b, k < a};
			ch_overdrive = od && (k == 0);
			@(negedge core_clk);
		end
		end_m(tt);
	endtask

	task automatic rnd;
		@(negedge core_clk);
		na = $urandom % 40;
		nb = $urandom % 40;
		nc = $urandom % 40;
		t = 12'($urandom);
		{sleep_live, shutdown_live} = 2'($urandom);
	endtask

	task automatic done(input string s);
		@(negedge core_clk);
		$display("test %s finished", s);
	endtask

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A hung design still reaches the closing report.
	initial
	begin
		#950000;
		failures++;
		report_and_stop();
	end

	initial
	begin
		{meas_start, meas_end, ch_overdrive, external_gate_mode, time_ref_enable} = '0;
		{in_measure_state, soft_reset, config_return, sleep_live, shutdown_live} = '0;
		{ch_count_inc, temp_sample, integration_code, operational_state_reg} = '0;
		rst_b = 1'b0;
		na = $urandom(95);
		cyc(20);
		rst_b = 1'b1;
		cyc(5);
		`CHK(ready_out, 1'b1)
		`CHK(temp_valid, 1'b0)
		pw(CH_ZERO);
		rd(ADDR_CH_A, 2);
		done("reset");
		repeat (2)
		begin
			rnd();
			measure(na, nb, nc, 40, 0, t);
			ps(st(0, 0, 0, 1, 0));
			rd(ADDR_STATUS, 2);
			pw({4'h0, t});
			pw(16'(na));
			pw(16'(nb));
			pw(16'(nc));
			rd(ADDR_TEMP, 8);
			ps(st(0, 0, 0, 0, 0));
			rd(ADDR_STATUS, 2);
		end
		done("basic");
		rnd();
		measure(7, 7, 7, 10, 0, t);
		measure(na, nb, nc, 40, 0, t);
		pw(16'(na));
		rd(ADDR_CH_A, 2);
		ps(st(0, 0, 1, 0, 0));
		rd(ADDR_STATUS, 2);
		ps(st(0, 0, 0, 0, 0));
		rd(ADDR_STATUS, 2);
		done("lost");
		rnd();
		measure(na, 0, 0, 40, 0, t);
		pw(16'(na));
		rd(ADDR_CH_A, 2, 1);
		measure(na + 1, 0, 0, 40, 0, t);
		pw(16'(na));
		rd(ADDR_CH_A, 2, 1);
		u_host.stop();
		pw(16'(na + 1));
		rd(ADDR_CH_A, 2);
		done("hold");
		rnd();
		in_measure_state = 1'b1;
		operational_state_reg = 8'($urandom);
		measure(na, nb, nc, 40, 1, t);
		ps(st(0, 1, 0, 1, 0));
		rd(ADDR_STATUS, 2);
		measure(0, 0, 0, 20, 0, t);
		start_m();
		// A second start while busy must be ignored.
		start_m();
		ps(st(0, 0, 0, 1, 1));
		rd(ADDR_STATUS, 2);
		end_m(t);
		pw(CH_ZERO);
		rd(ADDR_CH_A, 2);
		done("overdrive");
		in_measure_state = 1'b0;
		integration_code = 4'hF;
		measure(65540, 0, 0, 65540, 0, t);
		pw(CH_MAX);
		rd(ADDR_CH_A, 2);
		ps(st(1, 0, 0, 0, 0));
		rd(ADDR_STATUS, 2);
		done("saturate");
		external_gate_mode = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			rnd();
			time_ref_enable = (i != 0);
			measure(0, 0, 0, (i == 2) ? 4200 : 100, 0, t);
			pw((i == 0) ? 16'h0000 : {4'h0, t});
			rd(ADDR_TEMP, 2);
			// The period word counts every core edge from start to end strobe.
			pw((i == 0) ? 16'h0000 : 16'((i == 2) ? 4202 : 102));
			pw(16'h0000);
			rd(ADDR_CONV_LO, 4);
			`CHK(temp_valid, (i == 2))
		end
		done("temperature");
		external_gate_mode = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			measure(5, 5, 5, 20, 1, t);
			@(negedge core_clk);
			{soft_reset, config_return} = i ? 2'h1 : 2'h2;
			@(negedge core_clk);
			{soft_reset, config_return} = 2'h0;
			cyc(2);
			`CHK(temp_valid, 1'b0)
			pw(CH_ZERO);
			ps(st(0, 0, 0, 0, 0));
			rd(ADDR_CH_A, 2);
			rd(ADDR_STATUS, 2);
		end
		done("clear");
		if (exp_q.size() != 0)
			failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
